// file: inc/rt_mc_pkg.sv
/*
 Shared constants for the remote-terminal mode code and message status logic:
 register indices, field positions, mode code values and the state encoding.
 Assumes a single 100 MHz system clock and a word-wide register port.
*/
package rt_mc_pkg;

   // Register indices on the register port.
   localparam logic [4:0] REG_CTRL = 5'h00;
   localparam logic [4:0] REG_LAST_CMD = 5'h02;
   localparam logic [4:0] REG_BIT_WORD = 5'h06;
   localparam logic [4:0] REG_TIMER = 5'h07;
   localparam logic [4:0] REG_VECTOR = 5'h08;
   localparam logic [4:0] REG_AUX = 5'h09;
   localparam logic [4:0] REG_STATUS = 5'h0A;

   // Control register fields and the service request bit of the auxiliary register.
   localparam int CTRL_ENHANCED = 0;
   localparam int CTRL_DBA_EN = 1;
   localparam int CTRL_OVERRIDE_EN = 2;
   localparam int CTRL_TF_REQ = 3;
   localparam int SRQ_BIT = 8;

   // Message information word fields.
   localparam int MIW_CNT_LO = 11;
   localparam int MIW_BUS = 9;
   localparam int MIW_TERMINAL_TO_TERMINAL_FLAG = 8;
   localparam int MIW_ME = 7;
   localparam int MIW_BC = 5;
   localparam int MIW_ILL = 4;
   localparam int MIW_SHORT = 3;
   localparam int MIW_OVR = 2;
   localparam int MIW_PAR = 1;
   localparam int MIW_MAN = 0;

   // Status word fields and command word fields.
   localparam int ST_ADDR_LO = 11;
   localparam int ST_ME = 10;
   localparam int ST_SR = 8;
   localparam int ST_BCR = 4;
   localparam int ST_DBA = 1;
   localparam int ST_TF = 0;
   localparam int CMD_TR = 10;
   localparam logic [4:0] SA_MODE_A = 5'h00;
   localparam logic [4:0] SA_MODE_B = 5'h1F;
   localparam logic [5:0] FULL_WC = 6'h20;

   // Mode code values.
   localparam logic [4:0] MC_DYN_BUS = 5'h00;
   localparam logic [4:0] MC_SYNC = 5'h01;
   localparam logic [4:0] MC_TX_STATUS = 5'h02;
   localparam logic [4:0] MC_SELF_TEST = 5'h03;
   localparam logic [4:0] MC_SHUTDOWN = 5'h04;
   localparam logic [4:0] MC_OVR_SHUTDOWN = 5'h05;
   localparam logic [4:0] MC_INHIBIT_TF = 5'h06;
   localparam logic [4:0] MC_OVR_INHIBIT = 5'h07;
   localparam logic [4:0] MC_RESET_RT = 5'h08;
   localparam logic [4:0] MC_VECTOR = 5'h10;
   localparam logic [4:0] MC_SYNC_DATA = 5'h11;
   localparam logic [4:0] MC_LAST_CMD = 5'h12;
   localparam logic [4:0] MC_BIT_WORD = 5'h13;

   // Time-tag resolution.
   localparam int CLK_PERIOD_NS = 10;
   localparam int TICK_NS = 1000;
   localparam logic [6:0] TICK_CYCLES = 7'(TICK_NS / CLK_PERIOD_NS);

   typedef enum logic [3:0] {
      S_IDLE = 4'h1,
      S_RECV = 4'h2,
      S_STAT = 4'h4,
      S_DATA = 4'h8
   } state_t;

   // True when the command addresses a mode code subaddress.
   function automatic logic is_mode(input logic [15:0] cmd);
      return (cmd[9:5] == SA_MODE_A) || (cmd[9:5] == SA_MODE_B);
   endfunction

endpackage

// file: rtl/rt_time_tag_timer.sv
/*
 Time-tag counter with a fixed prescaler, a clear and a load.
 Assumes its controls come from logic on the same clock.
*/
`timescale 1ns/10ps
module rt_time_tag_timer (
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   input wire logic clr,
   input wire logic load,
   input wire logic [15:0] load_value,
   output logic [15:0] count
);

   typedef struct packed {
      logic [6:0] pre;
      logic [15:0] cnt;
   } tmr_t;

   tmr_t s;
   tmr_t n;

   // Clear beats load so a sync without data always lands on zero.
   always_comb begin
      n = s;
      if (clr) begin
         n.pre = 7'h00;
         n.cnt = 16'h0000;
      end else if (load) begin
         n.pre = 7'h00;
         n.cnt = load_value;
      end else if (s.pre == 7'(rt_mc_pkg::TICK_CYCLES - 7'h01)) begin
         n.pre = 7'h00;
         n.cnt = 16'(s.cnt + 16'h0001);
      end else begin
         n.pre = 7'(s.pre + 7'h01);
      end
   end

   // The clock enable freezes the prescaler as well as the count.
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         s <= '0;
      end else if (ce) begin
         s <= n;
      end
   end

   assign count = s.cnt;

endmodule

// file: rtl/rt_mode_code_status.sv
/*
 Remote-terminal message status writer and mode code executor: builds the
 message information word, captures the time tag and carries out mode codes.
 Assumes a word decoder on the same clock delivers validated commands, data
 words and an end-of-message pulse, and that a transmitter takes each word.
*/
// Overview of operation
// - Flag terminal-to-terminal transfers on receive.
// - Any error sets message error flag.
// - Enhanced mode: bit five marks broadcast.
// - Flag commands that were made illegal.
// - Flag receive messages with too few words.
// - Flag extra or unexpected data words.
// - Flag received data parity errors.
// - Flag received data encoding errors.
// - Capture timer when command is validated.
// - Keep last command except transmit-last-command.
// - Every mode code answers with status.
// - Four of sixteen registers (16..19) mark mode codes illegal.
// - Sync with data loads the timer.
// - Sync without data clears the timer.
// - Dynamic bus acceptance only when enabled.
// - Status cleared at reset; illegal updates it.
// - Self-test does nothing beyond status.
// - Shutdown alternate bus; reset or override clears.
// - Inhibit terminal flag; override re-enables it.
// - Vector word with service request; then clear.
// - Send previous command; legal updates status.
// - Send built-in-test register as data.
// - Bus select bit: one for bus A.
// - Count or code in top five bits.
`timescale 1ns/10ps
module rt_mode_code_status (
   input wire logic CLK_SYS,
   input wire logic RST_N,
   input wire logic CE,
   input wire logic [4:0] ADDR,
   input wire logic [15:0] WDATA,
   input wire logic WR_STB,
   input wire logic RD_STB,
   output logic [15:0] RDATA,
   input wire logic CMD_VALID,
   input wire logic [15:0] CMD_WORD,
   input wire logic CMD_BUS_A,
   input wire logic CMD_BCAST,
   input wire logic CMD_TERMINAL_TO_TERMINAL_FLAG,
   input wire logic DW_VALID,
   input wire logic [15:0] DW_WORD,
   input wire logic DW_PAR_ERR,
   input wire logic DW_MAN_ERR,
   input wire logic MSG_DONE,
   output logic MIW_VALID,
   output logic [15:0] MESSAGE_INFORMATION_WORD,
   output logic [15:0] MIW_TTAG,
   output logic TX_VALID,
   output logic [15:0] TX_WORD,
   output logic ALT_TX_DISABLE,
   output logic TERMINAL_FLAG
);

   typedef struct packed {
      rt_mc_pkg::state_t st;
      logic [15:0] ctrl;
      logic [15:0] aux;
      logic [15:0] bitw;
      logic [15:0] vec;
      logic [15:0] last_cmd;
      logic [15:0] cmd;
      logic [15:0] ttag;
      logic [15:0] dw;
      logic [15:0] status;
      logic [15:0][15:0] legal;
      logic bus_a;
      logic bcast;
      logic terminal_to_terminal_flag;
      logic illegal_command_flag;
      logic overrun_flag;
      logic par;
      logic bit_encoding_error_flag;
      logic [5:0] cnt;
      logic [5:0] expct;
      logic alt_dis;
      logic tf_inh;
      logic tm_load;
      logic tm_clr;
      logic miw_vld;
      logic tx_vld;
      logic alt_o;
      logic tf_o;
      logic [15:0] rdata;
      logic [15:0] message_information_word;
      logic [15:0] miw_tt;
      logic [15:0] tx_word;
   } core_t;

   localparam core_t RESET_STATE = '{st: rt_mc_pkg::S_IDLE, default: '0};

   core_t s;
   core_t n;
   logic [15:0] timer;
   logic [4:0] mc;
   logic tr;
   logic mode;

   assign mc = s.cmd[4:0];
   assign tr = s.cmd[rt_mc_pkg::CMD_TR];
   assign mode = rt_mc_pkg::is_mode(s.cmd);

   // A set bit in the bank makes the code illegal; regs 16..19 cover mode codes.
   function automatic logic illegal(input logic [15:0] cmd, input logic [15:0][15:0] bank);
      logic [3:0] row;
      row = {2'b00, cmd[rt_mc_pkg::CMD_TR], cmd[4]};
      return rt_mc_pkg::is_mode(cmd) && bank[row][cmd[3:0]];
   endfunction

   // Data words that a command calls for on receive; transmit expects none.
   function automatic logic [5:0] expected(input logic [15:0] cmd);
      logic [5:0] wc;
      wc = (cmd[4:0] == 5'h00) ? rt_mc_pkg::FULL_WC : {1'b0, cmd[4:0]};
      if (cmd[rt_mc_pkg::CMD_TR]) begin
         return 6'h00;
      end else if (rt_mc_pkg::is_mode(cmd)) begin
         return {5'h00, cmd[4]};
      end
      return wc;
   endfunction

   rt_time_tag_timer u_timer (
      .clk(CLK_SYS),
      .rst_n(RST_N),
      .ce(CE),
      .clr(s.tm_clr),
      .load(s.tm_load),
      .load_value(s.dw),
      .count(timer)
   );

   // Next-state logic: message sequence first, register writes last so that
   // software writing the service request bit wins over the hardware clear.
   always_comb begin
      logic short_msg;
      logic err;
      logic upd;
      logic [15:0] w;
      short_msg = 1'b0;
      err = 1'b0;
      upd = 1'b0;
      w = 16'h0000;
      n = s;
      n.miw_vld = 1'b0;
      n.tx_vld = 1'b0;
      n.tm_load = 1'b0;
      n.tm_clr = 1'b0;
      n.rdata = 16'h0000;
      unique case (s.st)
         rt_mc_pkg::S_IDLE: begin
            if (CMD_VALID) begin
               n.cmd = CMD_WORD;
               n.ttag = timer;
               n.bus_a = CMD_BUS_A;
               n.bcast = CMD_BCAST;
               n.terminal_to_terminal_flag = CMD_TERMINAL_TO_TERMINAL_FLAG;
               n.illegal_command_flag = illegal(CMD_WORD, s.legal);
               n.expct = expected(CMD_WORD);
               n.cnt = 6'h00;
               n.overrun_flag = 1'b0;
               n.par = 1'b0;
               n.bit_encoding_error_flag = 1'b0;
               n.st = rt_mc_pkg::S_RECV;
            end
         end
         rt_mc_pkg::S_RECV: begin
            if (DW_VALID) begin
               if (s.cnt >= s.expct) begin
                  n.overrun_flag = 1'b1;
               end
               if (s.cnt != 6'h3F) begin
                  n.cnt = 6'(s.cnt + 6'h01);
               end
               n.par = s.par | DW_PAR_ERR;
               n.bit_encoding_error_flag = s.bit_encoding_error_flag | DW_MAN_ERR;
               n.dw = DW_WORD;
            end
            if (MSG_DONE) begin
               n.st = rt_mc_pkg::S_STAT;
            end
         end
         rt_mc_pkg::S_STAT: begin
            short_msg = !tr && (s.cnt < s.expct);
            err = s.illegal_command_flag | short_msg | s.overrun_flag | s.par | s.bit_encoding_error_flag;
            // The unused bits six and ten stay at the zero of w.
            w[15:rt_mc_pkg::MIW_CNT_LO] = mc;
            w[rt_mc_pkg::MIW_BUS] = s.bus_a;
            w[rt_mc_pkg::MIW_TERMINAL_TO_TERMINAL_FLAG] = s.terminal_to_terminal_flag && !tr;
            w[rt_mc_pkg::MIW_ME] = err;
            w[rt_mc_pkg::MIW_BC] = s.bcast && s.ctrl[rt_mc_pkg::CTRL_ENHANCED];
            w[rt_mc_pkg::MIW_ILL] = s.illegal_command_flag;
            w[rt_mc_pkg::MIW_SHORT] = short_msg;
            w[rt_mc_pkg::MIW_OVR] = s.overrun_flag;
            w[rt_mc_pkg::MIW_PAR] = s.par && !tr;
            w[rt_mc_pkg::MIW_MAN] = s.bit_encoding_error_flag && !tr;
            n.message_information_word = w;
            n.miw_tt = s.ttag;
            n.miw_vld = 1'b1;
            n.st = rt_mc_pkg::S_IDLE;
            if (!(mode && tr && mc == rt_mc_pkg::MC_LAST_CMD)) begin
               n.last_cmd = s.cmd;
            end
            if (mode) begin
               // Fresh status word from this message.
               w = 16'h0000;
               w[15:rt_mc_pkg::ST_ADDR_LO] = s.cmd[15:11];
               w[rt_mc_pkg::ST_ME] = err;
               w[rt_mc_pkg::ST_SR] = s.aux[rt_mc_pkg::SRQ_BIT];
               w[rt_mc_pkg::ST_BCR] = s.bcast;
               w[rt_mc_pkg::ST_TF] = s.ctrl[rt_mc_pkg::CTRL_TF_REQ] && !s.tf_inh;
               // Transmit-status keeps the old word unless illegal; transmit-last
               // keeps it when illegal.
               upd = !(tr && mc == rt_mc_pkg::MC_TX_STATUS && !s.illegal_command_flag) &&
                     !(tr && mc == rt_mc_pkg::MC_LAST_CMD && s.illegal_command_flag);
               if (upd) begin
                  n.status = w;
               end
               n.tx_word = upd ? w : s.status;
               n.tx_vld = 1'b1;
               if (!s.illegal_command_flag) begin
                  if (tr) begin
                     unique case (mc)
                        rt_mc_pkg::MC_DYN_BUS: begin
                           n.tx_word[rt_mc_pkg::ST_DBA] = s.ctrl[rt_mc_pkg::CTRL_DBA_EN];
                        end
                        rt_mc_pkg::MC_SYNC: begin
                           n.tm_clr = 1'b1;
                        end
                        rt_mc_pkg::MC_SHUTDOWN: begin
                           n.alt_dis = 1'b1;
                        end
                        rt_mc_pkg::MC_OVR_SHUTDOWN: begin
                           if (s.ctrl[rt_mc_pkg::CTRL_OVERRIDE_EN]) begin
                              n.alt_dis = 1'b0;
                           end
                        end
                        rt_mc_pkg::MC_RESET_RT: begin
                           n.alt_dis = 1'b0;
                        end
                        rt_mc_pkg::MC_INHIBIT_TF: begin
                           n.tf_inh = 1'b1;
                        end
                        rt_mc_pkg::MC_OVR_INHIBIT: begin
                           n.tf_inh = 1'b0;
                        end
                        rt_mc_pkg::MC_VECTOR: begin
                           n.tx_word[rt_mc_pkg::ST_SR] = 1'b1;
                           n.aux[rt_mc_pkg::SRQ_BIT] = 1'b0;
                        end
                        default: begin
                           // Self-test and the rest answer with status; transmit-last and BIT word then add data.
                           n.tm_clr = 1'b0;
                        end
                     endcase
                  end else if (mc == rt_mc_pkg::MC_SYNC_DATA && !short_msg) begin
                     n.tm_load = 1'b1;
                  end
               end
               if (tr && mc[4] && !s.illegal_command_flag) begin
                  n.st = rt_mc_pkg::S_DATA;
               end
            end
         end
         rt_mc_pkg::S_DATA: begin
            n.tx_vld = 1'b1;
            n.st = rt_mc_pkg::S_IDLE;
            if (mc == rt_mc_pkg::MC_LAST_CMD) begin
               n.tx_word = s.last_cmd;
            end else if (mc == rt_mc_pkg::MC_BIT_WORD) begin
               n.tx_word = s.bitw;
            end else begin
               n.tx_word = s.vec;
            end
         end
         default: begin
            n.st = rt_mc_pkg::S_IDLE;
         end
      endcase
      if (WR_STB) begin
         if (ADDR[4]) begin
            n.legal[ADDR[3:0]] = WDATA;
         end else if (ADDR == rt_mc_pkg::REG_CTRL) begin
            n.ctrl = WDATA;
         end else if (ADDR == rt_mc_pkg::REG_BIT_WORD) begin
            n.bitw = WDATA;
         end else if (ADDR == rt_mc_pkg::REG_VECTOR) begin
            n.vec = WDATA;
         end else if (ADDR == rt_mc_pkg::REG_AUX) begin
            n.aux = WDATA;
         end
      end
      if (RD_STB) begin
         if (ADDR[4]) begin
            n.rdata = s.legal[ADDR[3:0]];
         end else begin
            unique case (ADDR)
               rt_mc_pkg::REG_CTRL: n.rdata = s.ctrl;
               rt_mc_pkg::REG_LAST_CMD: n.rdata = s.last_cmd;
               rt_mc_pkg::REG_BIT_WORD: n.rdata = s.bitw;
               rt_mc_pkg::REG_TIMER: n.rdata = timer;
               rt_mc_pkg::REG_VECTOR: n.rdata = s.vec;
               rt_mc_pkg::REG_AUX: n.rdata = s.aux;
               rt_mc_pkg::REG_STATUS: n.rdata = s.status;
               default: n.rdata = 16'h0000;
            endcase
         end
      end
      n.alt_o = n.alt_dis;
      n.tf_o = n.ctrl[rt_mc_pkg::CTRL_TF_REQ] && !n.tf_inh;
   end

   // Single state register; clock enable low freezes everything.
   always_ff @(posedge CLK_SYS) begin
      if (!RST_N) begin
         s <= RESET_STATE;
      end else if (CE) begin
         s <= n;
      end
   end

   assign RDATA = s.rdata;
   assign MIW_VALID = s.miw_vld;
   assign MESSAGE_INFORMATION_WORD = s.message_information_word;
   assign MIW_TTAG = s.miw_tt;
   assign TX_VALID = s.tx_vld;
   assign TX_WORD = s.tx_word;
   assign ALT_TX_DISABLE = s.alt_o;
   assign TERMINAL_FLAG = s.tf_o;

   // Checks hold only while the clock enable keeps running.
   default clocking cb @(posedge CLK_SYS); endclocking
   default disable iff (!RST_N || !CE);

   sequence s_fin(logic [4:0] c, logic t);
      s.st == rt_mc_pkg::S_STAT && mode && mc == c && tr == t && !s.illegal_command_flag;
   endsequence

   property p_unused_zero;
      MIW_VALID |-> !MESSAGE_INFORMATION_WORD[6] && !MESSAGE_INFORMATION_WORD[10];
   endproperty
   a_unused_zero: assert property (p_unused_zero) else $error("unused bits set");

   property p_me;
      MIW_VALID |-> MESSAGE_INFORMATION_WORD[rt_mc_pkg::MIW_ME] == (|MESSAGE_INFORMATION_WORD[4:0]);
   endproperty
   a_me: assert property (p_me) else $error("message error mismatch");

   property p_ttag;
      s.st == rt_mc_pkg::S_IDLE && CMD_VALID |=> s.ttag == $past(timer);
   endproperty
   a_ttag: assert property (p_ttag) else $error("time tag not captured");

   property p_status;
      s.st == rt_mc_pkg::S_STAT && mode |=> TX_VALID;
   endproperty
   a_status: assert property (p_status) else $error("no status for mode code");

   property p_sync;
      s_fin(rt_mc_pkg::MC_SYNC, 1'b1) |-> ##2 timer == 16'h0000;
   endproperty
   a_sync: assert property (p_sync) else $error("timer not cleared");

   property p_shutdown;
      s_fin(rt_mc_pkg::MC_SHUTDOWN, 1'b1) |=> ALT_TX_DISABLE;
   endproperty
   a_shutdown: assert property (p_shutdown) else $error("alternate bus still on");

   property p_inhibit;
      s.tf_inh |-> !TERMINAL_FLAG;
   endproperty
   a_inhibit: assert property (p_inhibit) else $error("flag while inhibited");

   property p_vector;
      s_fin(rt_mc_pkg::MC_VECTOR, 1'b1) |=> TX_VALID && TX_WORD[rt_mc_pkg::ST_SR] ##1 TX_VALID;
   endproperty
   a_vector: assert property (p_vector) else $error("vector sequence wrong");

   property p_last;
      s_fin(rt_mc_pkg::MC_LAST_CMD, 1'b1) |=> TX_VALID ##1 TX_VALID && TX_WORD == s.last_cmd;
   endproperty
   a_last: assert property (p_last) else $error("last command not sent");

endmodule

// file: testbench/cmd_source.sv
/*
 Stand-in for the word decoder that faces the bus controller: it hands over a validated
 command, its data words and the end-of-message pulse. Assumes the bench calls send only
 while the block is idle, on the block's own clock.
*/
`timescale 1ns/10ps
module cmd_source (
   input wire logic clk,
   output logic cmd_valid,
   output logic [15:0] cmd_word,
   output logic cmd_bus_a,
   output logic cmd_bcast,
   output logic cmd_terminal_to_terminal_flag,
   output logic dw_valid,
   output logic [15:0] dw_word,
   output logic dw_par_err,
   output logic dw_man_err,
   output logic msg_done
);
   // Quiet lines at time zero.
   initial begin
      {cmd_valid, dw_valid, msg_done, dw_par_err, dw_man_err} = 5'h00;
      {cmd_bus_a, cmd_bcast, cmd_terminal_to_terminal_flag} = 3'h0;
      cmd_word = 16'h0000;
      dw_word = 16'h0000;
   end

   // One message; errors ride on the last data word. Released words are inverted so a
   // stale value never looks valid by chance.
   task automatic send(input logic [15:0] cmd, input int n, input logic [4:0] fl, input logic [15:0] dw);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_word <= cmd;
      {cmd_bus_a, cmd_bcast, cmd_terminal_to_terminal_flag} <= fl[4:2];
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         cmd_valid <= 1'b0;
         cmd_word <= ~cmd;
         dw_valid <= 1'b1;
         dw_word <= dw + 16'(i);
         {dw_par_err, dw_man_err} <= (i == n - 1) ? fl[1:0] : 2'b00;
      end
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_word <= ~cmd;
      dw_valid <= 1'b0;
      dw_word <= ~dw_word;
      {dw_par_err, dw_man_err} <= 2'b00;
      msg_done <= 1'b1;
      @(posedge clk);
      msg_done <= 1'b0;
   endtask
endmodule

// file: testbench/tb_top.sv
/*
 Self-checking bench for the mode code and message status block: register port,
 random subaddress messages, every mode code in two control settings and illegal codes.
 Assumes the decoder stand-in in cmd_source and a 100 MHz clock.
*/
`timescale 1ns/10ps
module tb_top;
   localparam logic [4:0] RA [11] = '{5'h00, 5'h02, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h10, 5'h13, 5'h1F, 5'h0C};
   localparam logic [4:0] RWA [7] = '{5'h00, 5'h06, 5'h08, 5'h09, 5'h10, 5'h13, 5'h1F};
   localparam logic [15:0] RWM [7] = '{16'h000F, 16'hFFFF, 16'hFFFF, 16'h0100, 16'hFFFF, 16'hFFFF, 16'hFFFF};
   localparam logic [5:0] MC [13] = '{6'h20, 6'h21, 6'h22, 6'h23, 6'h24, 6'h25, 6'h26, 6'h27, 6'h28, 6'h30,
                                      6'h33, 6'h32, 6'h11};
   logic CLK_SYS = 1'b0;
   logic RST_N = 1'b0;
   logic CE = 1'b1;
   logic [4:0] ADDR = 5'h00;
   logic [15:0] WDATA = 16'h0000;
   logic WR_STB = 1'b0;
   logic RD_STB = 1'b0;
   logic [15:0] RDATA, CMD_WORD, DW_WORD, MESSAGE_INFORMATION_WORD, MIW_TTAG, TX_WORD;
   logic CMD_VALID, CMD_BUS_A, CMD_BCAST, CMD_TERMINAL_TO_TERMINAL_FLAG, DW_VALID, DW_PAR_ERR, DW_MAN_ERR, MSG_DONE;
   logic MIW_VALID, TX_VALID, ALT_TX_DISABLE, TERMINAL_FLAG;
   int err_total = 0;
   int tests_run = 0;
   int n;
   logic [15:0] r, t0, mw, tg, s0, s1, prev, ctrl, c, d, vec, bitw;
   logic [4:0] fl;
   logic v0, v1;
   logic alt = 1'b0;
   logic inh = 1'b0;

   // The clock toggles every half period.
   always #5 CLK_SYS = ~CLK_SYS;

   rt_mode_code_status dut (.CLK_SYS, .RST_N, .CE, .ADDR, .WDATA, .WR_STB, .RD_STB, .RDATA, .CMD_VALID,
      .CMD_WORD, .CMD_BUS_A, .CMD_BCAST, .CMD_TERMINAL_TO_TERMINAL_FLAG, .DW_VALID, .DW_WORD, .DW_PAR_ERR, .DW_MAN_ERR,
      .MSG_DONE, .MIW_VALID, .MESSAGE_INFORMATION_WORD, .MIW_TTAG, .TX_VALID, .TX_WORD, .ALT_TX_DISABLE, .TERMINAL_FLAG);
   cmd_source src (.clk(CLK_SYS), .cmd_valid(CMD_VALID), .cmd_word(CMD_WORD), .cmd_bus_a(CMD_BUS_A),
      .cmd_bcast(CMD_BCAST), .cmd_terminal_to_terminal_flag(CMD_TERMINAL_TO_TERMINAL_FLAG), .dw_valid(DW_VALID), .dw_word(DW_WORD),
      .dw_par_err(DW_PAR_ERR), .dw_man_err(DW_MAN_ERR), .msg_done(MSG_DONE));

   // Comparison helpers and the closing report.
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp) begin
         err_total++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // The timer may tick once between two looks at it.
   task automatic near(input logic [15:0] got, input logic [15:0] base);
      chk(got, (got === base + 16'h0001) ? base + 16'h0001 : base);
   endtask
   task automatic give_verdict();
      $display("Comparisons %0d, mismatches %0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   task automatic wr(input logic [4:0] a, input logic [15:0] dv);
      @(posedge CLK_SYS);
      ADDR <= a;
      WDATA <= dv;
      WR_STB <= 1'b1;
      @(posedge CLK_SYS);
      WR_STB <= 1'b0;
   endtask
   task automatic rd(input logic [4:0] a, output logic [15:0] dv);
      @(posedge CLK_SYS);
      ADDR <= a;
      RD_STB <= 1'b1;
      @(posedge CLK_SYS);
      RD_STB <= 1'b0;
      #1 dv = RDATA;
   endtask

   // Reference information word; words beyond the expected count are an overrun.
   function automatic logic [15:0] exp_miw(input logic [15:0] cw, input int k, input logic [4:0] f,
                                           input logic illegal_command_flag, input logic enh);
      logic tr;
      int need;
      logic [4:0] e;
      tr = cw[10];
      need = (cw[9:5] == 5'h00 || cw[9:5] == 5'h1F) ? int'(!tr && cw[4]) :
             (tr ? 0 : (cw[4:0] == 5'h00 ? 32 : int'(cw[4:0])));
      e = {illegal_command_flag, !tr && k < need, k > need, !tr && k > 0 && f[1], !tr && k > 0 && f[0]};
      return {cw[4:0], 1'b0, f[4], f[2] && !tr, |e, 1'b0, f[3] && enh, e};
   endfunction

   // One message with a bounded wait for the result and the words sent back.
   task automatic msg(input logic [15:0] cw, input int k, input logic [4:0] f, input logic [15:0] dw,
                      input logic illegal_command_flag, input logic enh);
      logic got;
      got = 1'b0;
      rd(5'h07, t0);
      src.send(cw, k, f, dw);
      for (int i = 0; i < 8 && !got; i++) begin
         #1;
         if (MIW_VALID === 1'b1) begin
            got = 1'b1;
            {mw, tg, v0, s0} = {MESSAGE_INFORMATION_WORD, MIW_TTAG, TX_VALID, TX_WORD};
            @(posedge CLK_SYS);
            #1 {v1, s1} = {TX_VALID, TX_WORD};
         end else
            @(posedge CLK_SYS);
      end
      if (!got) begin
         err_total++;
         give_verdict();
      end
      chk(mw, exp_miw(cw, k, f, illegal_command_flag, enh));
      near(tg, t0);
   endtask

   // Main sequence: reset, registers, random messages, mode codes, illegal codes.
   initial begin
      void'($urandom(32'hD5B3));
      repeat (6) @(posedge CLK_SYS);
      RST_N <= 1'b1;
      foreach (RA[i]) begin
         rd(RA[i], r);
         chk(r, 16'h0000);
      end
      foreach (RWA[i]) begin
         d = 16'($urandom());
         wr(RWA[i], d);
         rd(RWA[i], r);
         chk(r & RWM[i], d & RWM[i]);
         wr(RWA[i], 16'h0000);
      end
      wr(5'h0A, 16'hFFFF);
      rd(5'h0A, r);
      chk(r, 16'h0000);
      repeat (16) begin
         ctrl = 16'($urandom_range(0, 1));
         wr(5'h00, ctrl);
         c = {5'($urandom()), 1'($urandom()), 5'($urandom_range(1, 30)), 5'($urandom_range(0, 3))};
         n = c[10] ? int'($urandom_range(0, 1)) : (c[4:0] == 5'h00 ? 32 : int'(c[4:0])) + int'($urandom_range(0, 2)) - 1;
         fl = 5'($urandom());
         fl = c[10] ? (fl & 5'b11000) : fl;
         msg(c, n, fl, 16'($urandom()), 1'b0, ctrl[0]);
      end
      for (int p = 0; p < 2; p++) begin
         ctrl = p ? 16'h0001 : 16'h000F;
         vec = 16'($urandom());
         bitw = 16'($urandom());
         wr(5'h00, ctrl);
         wr(5'h09, 16'h0100);
         wr(5'h08, vec);
         wr(5'h06, bitw);
         foreach (MC[i]) begin
            c = {5'h05, MC[i][5], p ? 5'h1F : 5'h00, MC[i][4:0]};
            d = 16'($urandom());
            msg(c, int'(!c[10] && c[4]), 5'b10000, d, 1'b0, 1'b1);
            chk({v0, s0[15:10]}, {1'b1, 5'h05, 1'b0});
            case (MC[i])
               6'h20: chk(s0[1], ctrl[1]);
               6'h21: begin
                  rd(5'h07, r);
                  near(r, 16'h0000);
               end
               6'h30: begin
                  chk({v1, s0[8], s1}, {2'b11, vec});
                  rd(5'h09, r);
                  chk(r, 16'h0000);
               end
               6'h32: chk({v1, s1}, {1'b1, prev});
               6'h33: chk({v1, s1}, {1'b1, bitw});
               6'h11: begin
                  rd(5'h07, r);
                  near(r, d);
               end
               default: chk(v1, 1'b0);
            endcase
            alt = (MC[i] == 6'h24) ? 1'b1 : (MC[i] == 6'h28 || (MC[i] == 6'h25 && ctrl[2])) ? 1'b0 : alt;
            inh = (MC[i] == 6'h26) ? 1'b1 : (MC[i] == 6'h27) ? 1'b0 : inh;
            chk({ALT_TX_DISABLE, TERMINAL_FLAG}, {alt, ctrl[3] & !inh});
            prev = (MC[i] == 6'h32) ? prev : c;
            rd(5'h02, r);
            chk(r, prev);
         end
      end
      wr(5'h12, 16'h0008);
      wr(5'h13, 16'h0008);
      for (int k = 0; k < 2; k++) begin
         c = {5'h05, 1'b1, 5'h00, k ? 5'h13 : 5'h03};
         msg(c, 0, 5'b10000, 16'h0000, 1'b1, 1'b1);
         chk({v0, s0[10], v1}, 3'b110);
      end
      // A low clock enable must freeze the time-tag timer; 250 cycles would otherwise add at least two ticks.
      rd(5'h07, t0);
      @(posedge CLK_SYS);
      CE <= 1'b0;
      repeat (250) @(posedge CLK_SYS);
      CE <= 1'b1;
      rd(5'h07, r);
      near(r, t0);
      give_verdict();
   end
endmodule
